// *** rtl/pfc_pwm_defines.svh ***
`ifndef PFC_PWM_DEFINES_SVH
`define PFC_PWM_DEFINES_SVH

// ==========================================================
// register byte offsets
`define REG_CTRL      5'h00
`define REG_COUNT     5'h04
`define REG_CMP_A     5'h08
`define REG_CMP_B     5'h0C
`define REG_CAPTOP    5'h10
`define REG_STATUS    5'h14
`define REG_MASK      5'h18
`define REG_PINDIR    5'h1C

// ==========================================================
// control field positions
`define CTRL_MODE_LSB   0
`define CTRL_ACTA_LSB   4
`define CTRL_ACTB_LSB   6
`define CTRL_CSEL_LSB   8
`define CTRL_RESET      11'h000

// ==========================================================
// status / mask bit positions
`define ST_OVF   0
`define ST_CMPA  1
`define ST_CMPB  2
`define ST_CAP   3

// ==========================================================
// mode codes and counter limits
`define MODE_PFC_CAPTOP 4'h8
`define MODE_PFC_CMPA   4'h9
`define COUNT_BOTTOM    16'h0000
`define COUNT_ONE       16'h0001

// ==========================================================
// output action codes
`define ACT_OFF     2'h0
`define ACT_TOGGLE  2'h1
`define ACT_NONINV  2'h2
`define ACT_INV     2'h3

// ==========================================================
// prescaler selections and divide masks (divider minus one)
`define CSEL_STOP   3'h0
`define CSEL_DIV1   3'h1
`define CSEL_DIV8   3'h2
`define CSEL_DIV64  3'h3
`define CSEL_DIV256 3'h4
`define CSEL_DIV1K  3'h5
`define PRE_MASK_8    10'h007
`define PRE_MASK_64   10'h03F
`define PRE_MASK_256  10'h0FF
`define PRE_MASK_1K   10'h3FF

`endif

// *** rtl/pfc_pwm_pkg.sv ***
`include "pfc_pwm_defines.svh"

package pfc_pwm_pkg;
  typedef logic [15:0] count_t;
  typedef logic [3:0]  mode_t;
  typedef logic [2:0]  csel_t;
  typedef enum logic [1:0] {
    ACT_OFF    = `ACT_OFF,
    ACT_TOGGLE = `ACT_TOGGLE,
    ACT_NONINV = `ACT_NONINV,
    ACT_INV    = `ACT_INV
  } action_t;
endpackage : pfc_pwm_pkg

// *** rtl/tick_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pfc_pwm_defines.svh"

module tick_prescaler (
  // clock and reset
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // selection and tick out
  input  wire pfc_pwm_pkg::csel_t sel,
  output logic                   tick
);
  logic [9:0] pre_q;
  logic [9:0] pre_d;
  logic [9:0] mask;

  // ==========================================================
  // divide masks; unlisted selections stop the timer
  assign mask = (sel == `CSEL_DIV8)   ? `PRE_MASK_8   :
                (sel == `CSEL_DIV64)  ? `PRE_MASK_64  :
                (sel == `CSEL_DIV256) ? `PRE_MASK_256 :
                `PRE_MASK_1K;
  assign pre_d = pre_q + 10'h001;
  // free-running divider shared by all ratios, so a ratio change needs no restart
  assign tick = (sel == `CSEL_DIV1) ? 1'b1 :
                (sel >= `CSEL_DIV8 && sel <= `CSEL_DIV1K) ?
                ((pre_q & mask) == mask) : 1'b0;

  // ==========================================================
  // prescale counter
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pre_q <= 10'h000;
    end else if (CE) begin
      pre_q <= pre_d;
    end
  end
endmodule : tick_prescaler
`default_nettype wire

// *** rtl/pfc_pwm_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pfc_pwm_defines.svh"

module pfc_pwm_timer (
  // clock, reset, enable
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  // avalon-mm slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // interrupt
  output logic             IRQ,
  // compare output pins
  output logic             COMPARE_OUTPUT_A,
  output logic             COMPARE_OUTPUT_A_OE,
  output logic             COMPARE_OUTPUT_B,
  output logic             COMPARE_OUTPUT_B_OE
);

  // ==========================================================
  // state
  logic [10:0]               ctrl_q;
  pfc_pwm_pkg::count_t       counter_value_q;
  pfc_pwm_pkg::count_t       counter_value_d;
  logic                      count_up_q;
  logic                      count_up_d;
  pfc_pwm_pkg::count_t       cmp_buf_a_q;
  pfc_pwm_pkg::count_t       cmp_buf_b_q;
  pfc_pwm_pkg::count_t       compare_value_a_q;
  pfc_pwm_pkg::count_t       compare_value_b_q;
  pfc_pwm_pkg::count_t       capture_top_value_q;
  logic [3:0]                status_q;
  logic [3:0]                status_d;
  logic [3:0]                mask_q;
  logic [1:0]                pin_direction_bit_q;
  logic [1:0]                compare_output_q;
  logic                      ack_q;
  logic [31:0]               rdata_q;

  // ==========================================================
  // control fields
  pfc_pwm_pkg::mode_t   waveform_mode_select;
  pfc_pwm_pkg::action_t output_action_select_a;
  pfc_pwm_pkg::action_t output_action_select_b;
  pfc_pwm_pkg::csel_t   clock_select;
  assign waveform_mode_select   = ctrl_q[`CTRL_MODE_LSB +: 4];
  assign output_action_select_a = pfc_pwm_pkg::action_t'(ctrl_q[`CTRL_ACTA_LSB +: 2]);
  assign output_action_select_b = pfc_pwm_pkg::action_t'(ctrl_q[`CTRL_ACTB_LSB +: 2]);
  assign clock_select           = ctrl_q[`CTRL_CSEL_LSB +: 3];

  // ==========================================================
  // bus decode: one wait state, so read data come from a register
  logic        req;
  logic        take;
  logic        wr;
  logic [31:0] wmask;
  assign req             = AVS_READ | AVS_WRITE;
  assign take            = req & ack_q;
  assign wr              = AVS_WRITE & take;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA    = rdata_q;
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  logic wr_ctrl;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_captop;
  logic wr_status;
  logic wr_mask;
  logic wr_pindir;
  assign wr_ctrl   = wr & (AVS_ADDRESS == `REG_CTRL);
  assign wr_cmp_a  = wr & (AVS_ADDRESS == `REG_CMP_A);
  assign wr_cmp_b  = wr & (AVS_ADDRESS == `REG_CMP_B);
  assign wr_captop = wr & (AVS_ADDRESS == `REG_CAPTOP);
  assign wr_status = wr & (AVS_ADDRESS == `REG_STATUS);
  assign wr_mask   = wr & (AVS_ADDRESS == `REG_MASK);
  assign wr_pindir = wr & (AVS_ADDRESS == `REG_PINDIR);

  logic [31:0] wdata_m;
  assign wdata_m = AVS_WRITEDATA & wmask;

  // read mux; unmapped addresses read zero
  logic [31:0] rmux;
  assign rmux = (AVS_ADDRESS == `REG_CTRL)   ? {21'h000000, ctrl_q} :
                (AVS_ADDRESS == `REG_COUNT)  ? {16'h0000, counter_value_q} :
                (AVS_ADDRESS == `REG_CMP_A)  ? {16'h0000, cmp_buf_a_q} :
                (AVS_ADDRESS == `REG_CMP_B)  ? {16'h0000, cmp_buf_b_q} :
                (AVS_ADDRESS == `REG_CAPTOP) ? {16'h0000, capture_top_value_q} :
                (AVS_ADDRESS == `REG_STATUS) ? {28'h0000000, status_q} :
                (AVS_ADDRESS == `REG_MASK)   ? {28'h0000000, mask_q} :
                (AVS_ADDRESS == `REG_PINDIR) ? {30'h00000000, pin_direction_bit_q} :
                32'h00000000;

  // ==========================================================
  // tick source
  logic timer_tick_enable;
  tick_prescaler u_pre (
    .MCLK (MCLK),
    .RST  (RST),
    .CE   (CE),
    .sel  (clock_select),
    .tick (timer_tick_enable)
  );

  // ==========================================================
  // mode and TOP selection
  logic                pfc_mode;
  logic                top_is_a;
  pfc_pwm_pkg::count_t top_value;
  logic                step;
  assign pfc_mode  = (waveform_mode_select == `MODE_PFC_CAPTOP) |
                     (waveform_mode_select == `MODE_PFC_CMPA);
  assign top_is_a  = (waveform_mode_select == `MODE_PFC_CMPA);
  assign top_value = top_is_a ? compare_value_a_q : capture_top_value_q;
  // the tick only qualifies clocked logic, never clocks it
  assign step      = CE & timer_tick_enable & pfc_mode;

  // ==========================================================
  // counter position
  logic at_top;
  logic at_bottom;
  logic slope_up;
  assign at_top    = (counter_value_q == top_value);
  assign at_bottom = (counter_value_q == `COUNT_BOTTOM);
  // BOTTOM belongs to the rising slope, TOP to the falling one
  assign slope_up  = at_bottom | (count_up_q & ~at_top);

  // next count: TOP is held for exactly one tick, then down
  assign count_up_d = at_top ? 1'b0 :
                      at_bottom ? 1'b1 : count_up_q;
  assign counter_value_d =
      at_top    ? counter_value_q - `COUNT_ONE :
      at_bottom ? counter_value_q + `COUNT_ONE :
      count_up_q ? counter_value_q + `COUNT_ONE :
                   counter_value_q - `COUNT_ONE;

  // ==========================================================
  // compare matches per channel
  logic [1:0]           match;
  pfc_pwm_pkg::action_t act [2];
  pfc_pwm_pkg::count_t  cmp [2];
  logic [1:0]           out_d;
  assign act[0] = output_action_select_a;
  assign act[1] = output_action_select_b;
  assign cmp[0] = compare_value_a_q;
  assign cmp[1] = compare_value_b_q;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign match[ch] = (counter_value_q == cmp[ch]);
      // toggle is honoured on channel A with A as TOP only
      assign out_d[ch] =
          ~match[ch] ? compare_output_q[ch] :
          (act[ch] == pfc_pwm_pkg::ACT_NONINV) ? ~slope_up :
          (act[ch] == pfc_pwm_pkg::ACT_INV)    ?  slope_up :
          (act[ch] == pfc_pwm_pkg::ACT_TOGGLE && ch == 0 && top_is_a) ?
              ~compare_output_q[ch] :
          compare_output_q[ch];
    end
  endgenerate

  // ==========================================================
  // flag events; hardware set wins over a same-cycle clear
  logic [3:0] events;
  assign events[`ST_OVF]  = step & at_bottom;
  assign events[`ST_CMPA] = step & match[0];
  assign events[`ST_CMPB] = step & match[1];
  assign events[`ST_CAP]  = step & at_top & ~top_is_a;
  assign status_d = (status_q & ~(wr_status ? wdata_m[3:0] : 4'h0)) | events;
  assign IRQ      = |(status_q & mask_q);

  // ==========================================================
  // pins: a channel reaches its pin only when connected and set to output
  assign COMPARE_OUTPUT_A    = compare_output_q[0];
  assign COMPARE_OUTPUT_B    = compare_output_q[1];
  assign COMPARE_OUTPUT_A_OE = pin_direction_bit_q[0] &
                               (output_action_select_a != pfc_pwm_pkg::ACT_OFF);
  assign COMPARE_OUTPUT_B_OE = pin_direction_bit_q[1] &
                               (output_action_select_b != pfc_pwm_pkg::ACT_OFF);

  // ==========================================================
  // bus handshake and read data
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else if (CE) begin
      ack_q   <= req & ~ack_q;
      rdata_q <= (AVS_READ & ~ack_q) ? rmux : rdata_q;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_q              <= `CTRL_RESET;
      capture_top_value_q <= 16'h0000;
      mask_q              <= 4'h0;
      pin_direction_bit_q <= 2'h0;
      status_q            <= 4'h0;
    end else if (CE) begin
      if (wr_ctrl) ctrl_q <= (ctrl_q & ~wmask[10:0]) | wdata_m[10:0];
      if (wr_captop) capture_top_value_q <= (capture_top_value_q & ~wmask[15:0]) | wdata_m[15:0];
      if (wr_mask) mask_q <= (mask_q & ~wmask[3:0]) | wdata_m[3:0];
      if (wr_pindir) pin_direction_bit_q <= (pin_direction_bit_q & ~wmask[1:0]) | wdata_m[1:0];
      status_q <= status_d;
    end
  end

  // ==========================================================
  // compare buffers: software writes never touch the active values
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cmp_buf_a_q <= 16'h0000;
      cmp_buf_b_q <= 16'h0000;
    end else if (CE) begin
      if (wr_cmp_a) cmp_buf_a_q <= (cmp_buf_a_q & ~wmask[15:0]) | wdata_m[15:0];
      if (wr_cmp_b) cmp_buf_b_q <= (cmp_buf_b_q & ~wmask[15:0]) | wdata_m[15:0];
    end
  end

  // ==========================================================
  // counter, active compares and outputs advance on the tick only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      counter_value_q   <= `COUNT_BOTTOM;
      count_up_q        <= 1'b1;
      compare_value_a_q <= 16'h0000;
      compare_value_b_q <= 16'h0000;
      compare_output_q  <= 2'h0;
    end else if (step) begin
      counter_value_q  <= counter_value_d;
      count_up_q       <= count_up_d;
      compare_output_q <= out_d;
      // loading at BOTTOM keeps both slopes of a period equal
      if (at_bottom) begin
        compare_value_a_q <= cmp_buf_a_q;
        compare_value_b_q <= cmp_buf_b_q;
      end
    end
  end

endmodule : pfc_pwm_timer
`default_nettype wire

// *** tb/pfc_pwm_timer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checks for the pwm timer
module pfc_pwm_timer_assertions (
  // clock, reset, bus
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // interrupt and pins
  input wire logic        IRQ,
  input wire logic        COMPARE_OUTPUT_A,
  input wire logic        COMPARE_OUTPUT_A_OE,
  input wire logic        COMPARE_OUTPUT_B,
  input wire logic        COMPARE_OUTPUT_B_OE
);
  // any request standing on the bus
  wire logic req = AVS_READ | AVS_WRITE;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  first_wait_a: assert property ($rose(req) && CE |-> AVS_WAITREQUEST)
    else $error("request answered without wait state");
  one_wait_a: assert property (req && AVS_WAITREQUEST && CE ##1 CE |-> !AVS_WAITREQUEST)
    else $error("more than one wait state");
  short_ack_a: assert property (req && !AVS_WAITREQUEST |=> !(req && !AVS_WAITREQUEST))
    else $error("waitrequest low too long");
  ce_stall_a: assert property (req && !CE |-> AVS_WAITREQUEST)
    else $error("answer while enable low");
  rdata_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
    else $error("read data moved without read");
  ce_freeze_a: assert property (!CE |=> $stable({COMPARE_OUTPUT_A, COMPARE_OUTPUT_B, IRQ}))
    else $error("state moved while enable low");
  reset_quiet_a: assert property ($fell(RST) |-> !IRQ && !COMPARE_OUTPUT_A_OE && !COMPARE_OUTPUT_B_OE)
    else $error("outputs active out of reset");
  slope_gap_a: assert property ($changed(COMPARE_OUTPUT_A) |=> $stable(COMPARE_OUTPUT_A))
    else $error("output changed on adjacent ticks");
  oe_by_write_a: assert property ($changed(COMPARE_OUTPUT_A_OE) |-> $past(AVS_WRITE && !AVS_WAITREQUEST))
    else $error("pin enable moved without write");
  cover property (req && !AVS_WAITREQUEST);
  cover property ($rose(IRQ));
  cover property ($changed(COMPARE_OUTPUT_B));
endmodule : pfc_pwm_timer_assertions

bind pfc_pwm_timer pfc_pwm_timer_assertions u_chk (.MCLK(MCLK), .RST(RST), .CE(CE),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .COMPARE_OUTPUT_A(COMPARE_OUTPUT_A),
  .COMPARE_OUTPUT_A_OE(COMPARE_OUTPUT_A_OE), .COMPARE_OUTPUT_B(COMPARE_OUTPUT_B),
  .COMPARE_OUTPUT_B_OE(COMPARE_OUTPUT_B_OE));
`default_nettype wire

// *** tb/pwm_load.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// external load on one compare pin
module pwm_load (
  // clock and pin drive
  input  wire logic clk,
  input  wire logic drive,
  input  wire logic drive_oe,
  // line level and measures in clocks
  output logic      level,
  output int        high_len,
  output int        period
);
  int   run_q;
  int   hi_q;
  logic last_q;
  // pull-down: a released pin reads low, never the last value
  assign level = drive_oe ? drive : 1'b0;
  // a rising edge closes one period; a falling edge closes the high time
  always_ff @(posedge clk) begin
    last_q <= level;
    run_q <= run_q + 1;
    hi_q <= hi_q + int'(level);
    if (level && !last_q) begin
      period <= run_q;
      run_q <= 1;
      hi_q <= 1;
    end
    if (!level && last_q)
      high_len <= hi_q;
  end
endmodule : pwm_load
`default_nettype wire

// *** tb/dual_slope_symmetric_pwm_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pfc_pwm_defines.svh"
module dual_slope_symmetric_pwm_timer_tb;
  // ==========================================
  // stimulus and observation
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        wait_r, irq, out_a, oe_a, out_b, oe_b, lvl_a, lvl_b;
  int          hi_a, per_a, hi_b, per_b;
  int          err_total = 0;
  int          compares = 0;
  int          divs[5] = '{1, 8, 64, 256, 1024};
  // ==========================================
  // block and loads
  pfc_pwm_timer u_pfc_pwm_timer (.MCLK(MCLK), .RST(RST), .CE(CE), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_r), .IRQ(irq), .COMPARE_OUTPUT_A(out_a),
    .COMPARE_OUTPUT_A_OE(oe_a), .COMPARE_OUTPUT_B(out_b), .COMPARE_OUTPUT_B_OE(oe_b));
  pwm_load u_load_a (.clk(MCLK), .drive(out_a), .drive_oe(oe_a), .level(lvl_a),
    .high_len(hi_a), .period(per_a));
  pwm_load u_load_b (.clk(MCLK), .drive(out_b), .drive_oe(oe_b), .level(lvl_b),
    .high_len(hi_b), .period(per_b));
  // 200 MHz clock
  initial begin
    forever #2.5 MCLK = ~MCLK;
  end
  // ==========================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // one avalon access; raised just after a rising edge, held until waitrequest is sampled low
  // at a rising edge, where read data are taken; the leading edge keeps calls from overlapping
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge MCLK);
      n++;
    end while (wait_r !== 1'b0 && n < 200);
    if (n == 200)
      err_total++;
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  function automatic logic [31:0] ctl(logic [3:0] m, logic [1:0] a, logic [1:0] b, logic [2:0] s);
    return {21'h0, s, b, a, m};
  endfunction : ctl
  task automatic close_out;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // ==========================================
  // scenarios
  task automatic t_regs;
    bus(0, `REG_CTRL, 32'h0);
    check(v, 32'h0);
    bus(0, `REG_STATUS, 32'h0);
    check(v, 32'h0);
    bus(1, `REG_CMP_A, 32'h1234);
    bus(0, `REG_CMP_A, 32'h0);
    check(v, 32'h1234);
    bus(1, `REG_COUNT, 32'hAB);
    bus(0, `REG_COUNT, 32'h0);
    check(v, 32'h0);
    bus(1, `REG_CTRL, ctl(4'h0, 2'h0, 2'h0, 3'h0));
    bus(0, 5'h01, 32'h0);
    check(v, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // smallest top, every prescaler step; ordered so the divider only grows
  task automatic t_presc;
    bus(1, `REG_CAPTOP, 32'h3);
    bus(1, `REG_CMP_A, 32'h1);
    bus(1, `REG_PINDIR, 32'h1);
    for (int s = 0; s < 5; s++) begin
      bus(1, `REG_CTRL, ctl(`MODE_PFC_CAPTOP, `ACT_NONINV, `ACT_OFF, 3'(s + 1)));
      repeat (24 * divs[s] + 40) @(posedge MCLK);
      check(per_a, 6 * divs[s]);
      check(hi_a, 2 * divs[s]);
    end
    $display("test prescaler done");
  endtask : t_presc
  task automatic t_pwm;
    bus(1, `REG_CAPTOP, 32'h5);
    bus(1, `REG_CMP_A, 32'h2);
    bus(1, `REG_CMP_B, 32'h4);
    bus(1, `REG_PINDIR, 32'h3);
    bus(1, `REG_CTRL, ctl(`MODE_PFC_CAPTOP, `ACT_NONINV, `ACT_INV, `CSEL_DIV1));
    repeat (60) @(posedge MCLK);
    check(per_a, 10);
    check(hi_a, 4);
    check(per_b, 10);
    check(hi_b, 2);
    bus(0, `REG_COUNT, 32'h0);
    check(v <= 32'h5, 1'b1);
    $display("test pwm done");
  endtask : t_pwm
  // active compare a must reach 8 before it becomes top
  task automatic t_toggle;
    bus(1, `REG_CMP_A, 32'h8);
    repeat (20) @(posedge MCLK);
    bus(1, `REG_CTRL, ctl(`MODE_PFC_CMPA, `ACT_TOGGLE, `ACT_OFF, `CSEL_DIV1));
    repeat (100) @(posedge MCLK);
    check(per_a, 32);
    check(hi_a, 16);
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_extreme;
    bus(1, `REG_CAPTOP, 32'h8);
    // leave compare-a-as-top mode first: a zero buffer would otherwise become TOP
    bus(1, `REG_CTRL, ctl(`MODE_PFC_CAPTOP, `ACT_NONINV, `ACT_NONINV, `CSEL_DIV1));
    bus(1, `REG_CMP_A, 32'h0);
    bus(1, `REG_CMP_B, 32'h8);
    for (int p = 0; p < 2; p++) begin
      bus(1, `REG_CTRL, ctl(`MODE_PFC_CAPTOP, 2'(2 + p), 2'(2 + p), `CSEL_DIV1));
      repeat (40) @(posedge MCLK);
      repeat (8) begin
        @(negedge MCLK);
        check({lvl_b, lvl_a}, p ? 2'h1 : 2'h2);
      end
    end
    $display("test extremes done");
  endtask : t_extreme
  task automatic t_pins;
    bus(1, `REG_PINDIR, 32'h0);
    @(negedge MCLK);
    check({oe_b, oe_a, lvl_b, lvl_a, out_a}, 5'h01);
    bus(1, `REG_PINDIR, 32'h2);
    @(negedge MCLK);
    check({oe_b, oe_a, lvl_b, lvl_a}, 4'h8);
    $display("test pins done");
  endtask : t_pins
  task automatic t_flags;
    bus(1, `REG_STATUS, 32'hF);
    repeat (40) @(posedge MCLK);
    bus(0, `REG_STATUS, 32'h0);
    check(v, 32'hF);
    check(irq, 1'b0);
    fork
      bus(1, `REG_MASK, 32'h1);
      begin
        CE <= 1'b0;
        repeat (4) @(posedge MCLK);
        CE <= 1'b1;
      end
    join
    @(negedge MCLK);
    check(irq, 1'b1);
    bus(1, `REG_CTRL, ctl(`MODE_PFC_CAPTOP, `ACT_NONINV, `ACT_NONINV, `CSEL_STOP));
    bus(1, `REG_STATUS, 32'hF);
    repeat (20) @(posedge MCLK);
    bus(0, `REG_STATUS, 32'h0);
    check(v, 32'h0);
    check(irq, 1'b0);
    $display("test flags done");
  endtask : t_flags
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    t_regs;
    t_presc;
    t_pwm;
    t_toggle;
    t_extreme;
    t_pins;
    t_flags;
    close_out;
  end
  initial begin
    repeat (80000) @(posedge MCLK);
    err_total++;
    close_out;
  end
endmodule : dual_slope_symmetric_pwm_timer_tb
`default_nettype wire
